/* src/rcs_pkg.sv */
// Constants, state codes and carrier types shared by the reset, clock and
// supply sequencer and its two helper modules.
// Assumes a single 125 MHz clock and an APB register port of 32-bit words.
package rcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry and register map.
  localparam int          APB_AW       = 12;       // APB address width.
  localparam logic [11:0] SYSTEM_INTEGRITY_CTRL_STATUS_OFF    = 12'h000;  // Integrity control/status.
  localparam logic [11:0] SEQ_STAT_OFF = 12'h004;  // Sequencer status.
  localparam logic [7:0]  SYSTEM_INTEGRITY_CTRL_STATUS_RST    = 8'h00;    // Control value after reset.

  // Field positions inside the integrity control/status register.
  localparam int IE_BIT  = 6;                      // Warning interrupt enable.
  localparam int WF_BIT  = 5;                      // Supply warning flag.
  localparam int LRF_BIT = 4;                      // Low-voltage reset flag.
  localparam int WRF_BIT = 0;                      // Watchdog reset flag.

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 8;                // Clock period in ns.
  localparam int WDG_PULSE_NS  = 1000;             // Least watchdog pin pulse.
  localparam int WDG_PULSE_CYC =
    (WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_SHORT_CYC = 256;              // Short stabilisation delay.
  localparam int DLY_LONG_CYC  = 4096;             // Long stabilisation delay.
  localparam int FETCH_CYC     = 2;                // Vector fetch length.
  localparam int CNT_W         = 13;               // Phase counter width.

  // Reset vector locations at the top of the memory map.
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;  // Vector low byte.
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;  // Vector high byte.

  // Clock source codes: zero is the external clock, one to five resonators.
  localparam logic [2:0] OSC_EXT       = 3'h0;     // External clock input.
  localparam logic [2:0] OSC_RANGE_MAX = 3'h5;     // Highest resonator range.

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,                              // Core running.
    ST_ACT = 4'b0010,                              // Source-dependent phase.
    ST_DLY = 4'b0100,                              // Stabilisation delay.
    ST_FET = 4'b1000                               // Reset vector fetch.
  } rcs_state_e;

  // Non-volatile option settings.
  typedef struct packed {
    logic       pll_en;                            // Frequency doubler on.
    logic [2:0] osc_sel;                           // Clock source choice.
    logic       long_dly;                          // 4096-cycle delay.
    logic       lvd_en;                            // Low-voltage detector on.
  } rcs_opt_s;

  // Clock path controls sent to the analogue clock block.
  typedef struct packed {
    logic       mult2;                             // Core clock = 2 x osc.
    logic       half;                              // Core clock = osc / 2.
    logic [2:0] osc_sel;                           // Oscillator selection.
    logic       osc_run;                           // Oscillator kept running.
  } rcs_clk_s;

  // Counter load value that makes a phase last the given number of cycles.
  function automatic logic [CNT_W-1:0] cnt_load(input int cycles);
    return CNT_W'(cycles - 1);
  endfunction

endpackage

/* src/rcs_sync2.sv */
// Two-stage synchroniser with asynchronous assertion.
// Assumes arst_n may fall at any time; its rise is released on pclk.
`timescale 1ns/100ps
module rcs_sync2 (
  input  wire logic pclk,     // System clock.
  input  wire logic arst_n,   // Asynchronous request, active low.
  output logic      req       // Synchronised request, high while held.
);

  logic stage1_r;             // First stage, read only by the second.

  // Assert at once, release after two clean edges.
  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= 1'b1;
      req      <= 1'b1;
    end else begin
      stage1_r <= 1'b0;
      req      <= stage1_r;
    end
  end

endmodule

/* src/rcs_down_cnt.sv */
// Loadable down counter that times the phases of the reset sequence.
// Assumes load is a single-cycle command from the sequencer.
`timescale 1ns/100ps
module rcs_down_cnt #(
  parameter int W = 13        // Counter width.
) (
  input  wire logic         pclk,      // System clock.
  input  wire logic         presetn,   // Asynchronous reset, active low.
  input  wire logic         load,      // Load the start value.
  input  wire logic [W-1:0] load_val,  // Start value.
  output logic              zero       // Count has reached zero.
);

  logic [W-1:0] cnt_r;        // Remaining cycles.

  // Load wins; otherwise count down and stop at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  // Zero flag for the sequencer.
  assign zero = (cnt_r == '0);

endmodule

/* src/rcs_sequencer.sv */
// Reset sequencer with clock path selection and supply integrity logic.
// Assumes synchronous option, comparator and watchdog inputs, a reset pin
// with an external weak pull-up, and an APB master on pclk.
//
// What this block does
// - Doubler gives twice oscillator, else half.
// - Option selects external clock or resonator.
// - Oscillator keeps running through every reset.
// - Pin, low-voltage and watchdog start reset.
// - Reset pin driven low during delay.
// - Active phase, 256/4096 delay, then fetch.
// - Fetch lasts two cycles at top addresses.
// - Start address taken from fixed top vector.
// - Low pin forces reset without clock.
// - Pin is input and open-drain output.
// - Static reset while supply is low.
// - Pin driven low during low-voltage reset.
// - Detector option off disables its reset.
// - Watchdog drives pin for minimum pulse.
// - Warning flag readable, read-only, real time.
// - Warning works only with detector option.
// - Interrupt on every warning flag toggle while enabled.
// - No interrupt for crossings during reset.
// - Enable while low raises one now.
// - Enable after recovery gives one interrupt.
// - Bit 6 enable, bit 5 flag.
// - Service entry clears pending warning interrupt.
// - Bit 4 low-voltage flag, software zero clears.
// - Bit 0 watchdog flag, cleared by low-voltage.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module rcs_sequencer (
  input  wire logic                       pclk,           // System clock.
  input  wire logic                       presetn,        // Reset, active low.
  // APB slave port.
  input  wire logic                       psel,           // Slave select.
  input  wire logic                       penable,        // Access phase.
  input  wire logic                       pwrite,         // Write transfer.
  input  wire logic [rcs_pkg::APB_AW-1:0] paddr,          // Byte address.
  input  wire logic [31:0]                pwdata,         // Write data.
  output logic [31:0]                     prdata,         // Read data.
  output logic                            pready,         // Transfer done.
  output logic                            pslverr,        // Unmapped address.
  // Option settings and analogue inputs.
  input  wire rcs_pkg::rcs_opt_s          opt,            // Option settings.
  input  wire logic                       lvd_below_i,    // Supply under LOW_VOLTAGE_DETECTOR.
  input  wire logic                       avd_below_i,    // Supply under AUXILIARY_SUPPLY_WARNING.
  input  wire logic                       wdg_underflow_i,// Watchdog pulse.
  input  wire logic                       irq_ack_i,      // ISR entered.
  // Open-drain reset pin.
  input  wire logic                       rst_pin_i,      // Pin level.
  output logic                            rst_pin_o,      // Pin drive value.
  output logic                            rst_pin_oe_n,   // Drive, active low.
  // Core side.
  output logic                            core_reset_o,   // Core held reset.
  output logic                            vec_fetch_o,    // Vector fetch.
  output logic [15:0]                     vec_addr_o,     // Vector address.
  output logic                            avd_irq_o,      // Warning interrupt.
  output rcs_pkg::rcs_clk_s               clk_ctl_o       // Clock path setup.
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  rcs_pkg::rcs_state_e          state_r;      // Sequencer state.
  rcs_pkg::rcs_state_e          state_nxt;    // Next sequencer state.
  logic                         pin_drive_r;  // Device pulls the pin low.
  logic                         pin_drive_nxt;// Next pin drive.
  logic                         pin_drive_d_r;// Pin drive, one edge late.
  logic                         ext_arst_n;   // Pin request, active low.
  logic                         ext_req;      // Synchronised pin request.
  logic                         src_lvd;      // Low-voltage reset source.
  logic                         src_wdg;      // Watchdog reset source.
  logic                         wdg_pulse_r;  // Watchdog pulse in progress.
  logic                         cnt_load;     // Load the phase counter.
  logic [rcs_pkg::CNT_W-1:0]    cnt_val;      // Phase counter start value.
  logic                         cnt_zero;     // Phase counter expired.
  logic                         irq_en_r;     // Warning interrupt enable.
  logic                         lvd_rf_r;     // Low-voltage reset flag.
  logic                         wdg_rf_r;     // Watchdog reset flag.
  logic                         warn_flag;    // Live supply warning flag.
  logic                         warn_prev_r;  // Flag one cycle earlier.
  logic                         irq_pend_r;   // Pending warning interrupt.
  logic                         en_rise;      // Enable just set.
  logic                         wr_en;        // Write takes effect.
  logic                         setup;        // Setup cycle of a transfer.
  logic [31:0]                  rd_mux;       // Read data selected.
  logic                         rd_err;       // Address not mapped.
  logic [7:0]                   system_integrity_ctrl_status;        // Control/status image.

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources.

  // The pin is watched only while the device is not pulling it itself, nor
  // in the cycle after it lets go while the pin rises, so its own drive does
  // not feed back as a fresh external request.
  assign ext_arst_n = presetn &
                      (rst_pin_i | pin_drive_r | pin_drive_d_r);

  // Pin request asserts at once and releases after two clean edges.
  rcs_sync2 u_pin_sync (
    .pclk   (pclk),
    .arst_n (ext_arst_n),
    .req    (ext_req)
  );

  // The detector only resets the device when its option is selected.
  assign src_lvd = opt.lvd_en & lvd_below_i;

  // A watchdog underflow is a one-cycle event.
  assign src_wdg = wdg_underflow_i;

  ////////////////////////////////////////////////////////////////////////////
  // Phase timer shared by the watchdog pulse, the delay and the fetch.
  rcs_down_cnt #(
    .W (rcs_pkg::CNT_W)
  ) u_phase_cnt (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (cnt_load),
    .load_val (cnt_val),
    .zero     (cnt_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state, counter loads and pin drive.
  always_comb begin
    state_nxt     = state_r;
    cnt_load      = 1'b0;
    cnt_val       = '0;
    pin_drive_nxt = 1'b0;
    case (state_r)
      rcs_pkg::ST_RUN: begin
        // Any of the three sources starts the same sequence.
        if (src_wdg) begin
          state_nxt = rcs_pkg::ST_ACT;
          cnt_load  = 1'b1;
          cnt_val   = rcs_pkg::cnt_load(rcs_pkg::WDG_PULSE_CYC);
        end else if (src_lvd || ext_req) begin
          state_nxt = rcs_pkg::ST_ACT;
        end
      end
      rcs_pkg::ST_ACT: begin
        if (src_wdg) begin
          // A second underflow restarts the least pulse width.
          cnt_load = 1'b1;
          cnt_val  = rcs_pkg::cnt_load(rcs_pkg::WDG_PULSE_CYC);
        end else if (!src_lvd && !ext_req && cnt_zero) begin
          // Every source has let go: start the stabilisation delay.
          state_nxt = rcs_pkg::ST_DLY;
          cnt_load  = 1'b1;
          cnt_val   = opt.long_dly ?
                      rcs_pkg::cnt_load(rcs_pkg::DLY_LONG_CYC) :
                      rcs_pkg::cnt_load(rcs_pkg::DLY_SHORT_CYC);
        end
      end
      rcs_pkg::ST_DLY: begin
        if (src_wdg || src_lvd) begin
          // A new watchdog or low-voltage source during the delay goes back to the active phase.
          state_nxt = rcs_pkg::ST_ACT;
          cnt_load  = src_wdg;
          cnt_val   = rcs_pkg::cnt_load(rcs_pkg::WDG_PULSE_CYC);
        end else if (cnt_zero) begin
          state_nxt = rcs_pkg::ST_FET;
          cnt_load  = 1'b1;
          cnt_val   = rcs_pkg::cnt_load(rcs_pkg::FETCH_CYC);
        end
      end
      rcs_pkg::ST_FET: begin
        if (src_wdg || src_lvd || ext_req) begin
          state_nxt = rcs_pkg::ST_ACT;
          cnt_load  = src_wdg;
          cnt_val   = rcs_pkg::cnt_load(rcs_pkg::WDG_PULSE_CYC);
        end else if (cnt_zero) begin
          state_nxt = rcs_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = rcs_pkg::ST_ACT;
      end
    endcase
    // Pin pulled low for the delay, a low supply and a watchdog pulse.
    if (state_nxt == rcs_pkg::ST_DLY) begin
      pin_drive_nxt = 1'b1;
    end else if (state_nxt == rcs_pkg::ST_ACT) begin
      pin_drive_nxt = src_lvd | src_wdg |
                      (wdg_pulse_r & ~cnt_zero);
    end
  end

  // State register; power-up starts in the active phase so a full
  // sequence runs before the core is released.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rcs_pkg::ST_ACT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pin drive register and its late copy; the pin only ever pulls low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_drive_r   <= 1'b0;
      pin_drive_d_r <= 1'b0;
    end else begin
      pin_drive_r   <= pin_drive_nxt;
      pin_drive_d_r <= pin_drive_r;
    end
  end

  // Remembers that the active phase is timing a watchdog pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_pulse_r <= 1'b0;
    end else if (src_wdg) begin
      wdg_pulse_r <= 1'b1;
    end else if (state_r != rcs_pkg::ST_ACT) begin
      wdg_pulse_r <= 1'b0;
    end
  end

  // Open-drain pin: value is always low, enable is low while pulling.
  assign rst_pin_o    = 1'b0;
  assign rst_pin_oe_n = ~pin_drive_r;

  // Core reset follows the pin request at once, even with no clock.
  assign core_reset_o = (state_r != rcs_pkg::ST_RUN) | ext_req;

  ////////////////////////////////////////////////////////////////////////////
  // Vector fetch: low byte address first, then high byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_fetch_o <= 1'b0;
      vec_addr_o  <= rcs_pkg::VEC_LO_ADDR;
    end else if (state_nxt == rcs_pkg::ST_FET) begin
      vec_fetch_o <= 1'b1;
      vec_addr_o  <= (state_r == rcs_pkg::ST_FET) ?
                     rcs_pkg::VEC_HI_ADDR : rcs_pkg::VEC_LO_ADDR;
    end else begin
      vec_fetch_o <= 1'b0;
      vec_addr_o  <= rcs_pkg::VEC_LO_ADDR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock path set by the options; oscillator never stops in reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctl_o <= '{mult2: 1'b0, half: 1'b1,
                     osc_sel: rcs_pkg::OSC_EXT, osc_run: 1'b1};
    end else begin
      clk_ctl_o.mult2   <= opt.pll_en;
      clk_ctl_o.half    <= ~opt.pll_en;
      clk_ctl_o.osc_sel <= (opt.osc_sel > rcs_pkg::OSC_RANGE_MAX) ?
                           rcs_pkg::OSC_EXT : opt.osc_sel;
      clk_ctl_o.osc_run <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply warning flag and interrupt.

  // Live comparator output, forced inactive without the detector option.
  assign warn_flag = opt.lvd_en & avd_below_i;

  // Write strobe for the control/status register.
  assign wr_en = psel & penable & pwrite &
                 (paddr == rcs_pkg::SYSTEM_INTEGRITY_CTRL_STATUS_OFF);

  // Enable; forced clear through any reset so crossings inside the
  // reset sequence raise nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= rcs_pkg::SYSTEM_INTEGRITY_CTRL_STATUS_RST[rcs_pkg::IE_BIT];
    end else if (core_reset_o || !opt.lvd_en) begin
      irq_en_r <= 1'b0;
    end else if (wr_en) begin
      irq_en_r <= pwdata[rcs_pkg::IE_BIT] & opt.lvd_en;
    end
  end

  // Previous flag value for toggle detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_prev_r <= 1'b0;
    end else begin
      warn_prev_r <= warn_flag;
    end
  end

  // Setting the enable raises one interrupt for the current flag state.
  assign en_rise = wr_en & pwdata[rcs_pkg::IE_BIT] & ~irq_en_r &
                   opt.lvd_en & ~core_reset_o;

  // Pending interrupt: set on each toggle while enabled, cleared on
  // service entry; a new event in the acknowledge cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_r <= 1'b0;
    end else if ((irq_en_r && (warn_flag != warn_prev_r)) || en_rise) begin
      irq_pend_r <= 1'b1;
    end else if (irq_ack_i || !irq_en_r) begin
      irq_pend_r <= 1'b0;
    end
  end

  assign avd_irq_o = irq_pend_r & irq_en_r;

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause flags; hardware set wins over a software clear.

  // Low-voltage flag survives later pin and watchdog resets.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvd_rf_r <= rcs_pkg::SYSTEM_INTEGRITY_CTRL_STATUS_RST[rcs_pkg::LRF_BIT];
    end else if (src_lvd) begin
      lvd_rf_r <= 1'b1;
    end else if (wr_en && !pwdata[rcs_pkg::LRF_BIT]) begin
      lvd_rf_r <= 1'b0;
    end
  end

  // Watchdog flag; a low-voltage reset clears it ahead of all else.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_rf_r <= rcs_pkg::SYSTEM_INTEGRITY_CTRL_STATUS_RST[rcs_pkg::WRF_BIT];
    end else if (src_lvd) begin
      wdg_rf_r <= 1'b0;
    end else if (src_wdg) begin
      wdg_rf_r <= 1'b1;
    end else if (wr_en && !pwdata[rcs_pkg::WRF_BIT]) begin
      wdg_rf_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path: data is captured in the setup cycle and presented in
  // the access phase, which always completes in one cycle.

  // Register image with reserved bits reading zero.
  assign system_integrity_ctrl_status = {1'b0, irq_en_r, warn_flag, lvd_rf_r,
                  3'h0, wdg_rf_r};

  assign setup = psel & ~penable;

  // Address decode for reads.
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == rcs_pkg::SYSTEM_INTEGRITY_CTRL_STATUS_OFF) begin
      rd_mux = {24'h00_0000, system_integrity_ctrl_status};
    end else if (paddr == rcs_pkg::SEQ_STAT_OFF) begin
      rd_mux = {18'h0_0000, opt, 2'h0, core_reset_o, pin_drive_r,
                state_r};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Read data and error registered at the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= rd_err;
    end
  end

  // Zero wait states.
  assign pready = 1'b1;

endmodule

/* test/rcs_sequencer_monitor.sv */
// Checker for the reset sequencer, watching its ports only.
// Assumes it is bound onto rcs_sequencer by the testbench top.
`timescale 1ns/100ps
module rcs_sequencer_monitor (
  input wire logic              pclk,            // Clock.
  input wire logic              presetn,         // Reset, active low.
  input wire logic              psel,            // APB select.
  input wire logic              penable,         // APB access.
  input wire logic              pready,          // APB done.
  input wire rcs_pkg::rcs_opt_s opt,             // Options.
  input wire logic              lvd_below_i,     // Low supply.
  input wire logic              wdg_underflow_i, // Watchdog pulse.
  input wire logic              rst_pin_i,       // Pin level.
  input wire logic              rst_pin_o,       // Pin value.
  input wire logic              rst_pin_oe_n,    // Pin drive.
  input wire logic              core_reset_o,    // Core reset.
  input wire logic              vec_fetch_o,     // Fetch.
  input wire logic [15:0]       vec_addr_o       // Vector address.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Low vector first, then high vector, then the fetch is over.
  sequence fetch_seq;
    vec_addr_o == 16'hFFFE ##1 vec_fetch_o && vec_addr_o == 16'hFFFF
      ##1 !vec_fetch_o;
  endsequence
  fetch_two_a:
    assert property ($rose(vec_fetch_o) |-> fetch_seq)
    else $error("vector fetch wrong");
  pin_open_a:
    assert property (!rst_pin_oe_n |-> !rst_pin_o) else $error("pin high");
  pin_core_a:
    assert property (!rst_pin_i |-> core_reset_o) else $error("no reset");
  apb_ready_a:
    assert property (psel && penable |-> pready) else $error("not ready");
  lvd_pin_a:
    assert property (opt.lvd_en && lvd_below_i |-> ##[1:2] !rst_pin_oe_n)
    else $error("pin free in low supply");
  wdg_pin_a:
    assert property (wdg_underflow_i && !core_reset_o
      |-> ##[1:2] !rst_pin_oe_n [*8]) else $error("watchdog pin short");
  dly_pin_a:
    assert property ($rose(vec_fetch_o) |-> $past(rst_pin_oe_n, 2) == 1'b0)
    else $error("pin free in delay");
  run_fetch_a:
    assert property ($fell(core_reset_o) |-> $past(vec_fetch_o))
    else $error("run without fetch");
endmodule

/* test/rcs_board.sv */
// Board model: pulled-up open-drain reset pin and supply comparators.
// Assumes the bench sets the levels just after pclk rises.
`timescale 1ns/100ps
module rcs_board (
  input  wire logic pclk,      // Clock.
  input  wire logic ext_low,   // Board pulls the pin low.
  input  wire logic lvd_low,   // Supply under detector level.
  input  wire logic avd_low,   // Supply under warning level.
  input  wire logic pin_o,     // Device pin value.
  input  wire logic pin_oe_n,  // Device drive, active low.
  output logic      pin_i,     // Resolved pin level.
  output logic      lvd_below, // Detector output.
  output logic      avd_below  // Warning output.
);
  // Either side may pull low; otherwise the pull-up wins.
  assign pin_i = !(ext_low || (!pin_oe_n && !pin_o));
  // Comparators settle on the clock, as the design samples them.
  always_ff @(posedge pclk) begin
    lvd_below <= lvd_low;
    avd_below <= avd_low;
  end
endmodule

/* test/tb_rcs_sequencer.sv */
// Self-checking bench for the reset sequencer.
// Assumes the package, design, board model and checker are compiled.
`timescale 1ns/100ps
module tb_rcs_sequencer;
  logic pclk, presetn, psel, penable, pwrite, pready, err; // APB.
  logic wdg, ack, ext, low_voltage_detector, auxiliary_supply_warning, pin_i, pin_o, oe_n;      // Stimuli, pin.
  logic core, fet, irq, lvd_b, avd_b;                     // Observed.
  logic [11:0] paddr;                                     // Address.
  logic [15:0] vaddr;                                     // Vector.
  logic [31:0] pwdata, prdata, rd;                        // Data.
  rcs_pkg::rcs_opt_s opt;                                 // Options.
  rcs_pkg::rcs_clk_s clk_ctl;                             // Clock path.
  int errors, checks_done, n_oe, n_fet;                   // Counters.
  rcs_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr(err), .opt, .lvd_below_i(lvd_b),
    .avd_below_i(avd_b), .wdg_underflow_i(wdg), .irq_ack_i(ack),
    .rst_pin_i(pin_i), .rst_pin_o(pin_o), .rst_pin_oe_n(oe_n),
    .core_reset_o(core), .vec_fetch_o(fet), .vec_addr_o(vaddr),
    .avd_irq_o(irq), .clk_ctl_o(clk_ctl));
  rcs_board board (.pclk, .ext_low(ext), .lvd_low(low_voltage_detector), .avd_low(auxiliary_supply_warning),
    .pin_o, .pin_oe_n(oe_n), .pin_i, .lvd_below(lvd_b), .avd_below(avd_b));
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; read data is taken at the access edge.
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Runs a reset to its end, counting pin drive and fetch cycles.
  task automatic run_out();
    n_oe = 0;
    n_fet = 0;
    #1;
    for (int n = 0; n < 6000 && core !== 1'b0; n++) begin
      @(negedge pclk);
      n_oe += int'(oe_n === 1'b0);
      n_fet += int'(fet === 1'b1);
    end
    @(posedge pclk);
  endtask
  task automatic t_ext(logic lng);
    opt.long_dly <= lng;
    ext <= 1'b1;
    #1 chk("core reset", 1, core);
    repeat (5) @(posedge pclk);
    ext <= 1'b0;
    run_out();
    chk("delay drive", lng ? 4096 : 256, n_oe);
    chk("fetch", 2, n_fet);
    $display("test ext done");
  endtask
  task automatic t_wdg();
    wdg <= 1'b1;
    @(posedge pclk);
    wdg <= 1'b0;
    run_out();
    chk("wdg drive", rcs_pkg::WDG_PULSE_CYC + 256, n_oe);
    apb(0, 12'h000, 0);
    chk("wdg flag", 32'h0000_0001, rd);
    apb(1, 12'h000, 0);
    apb(0, 12'h008, 0);
    chk("unmapped", 1, err);
    $display("test wdg done");
  endtask
  task automatic t_lvd();
    low_voltage_detector <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("lvd pin", 0, pin_i);
    low_voltage_detector <= 1'b0;
    run_out();
    apb(0, 12'h000, 0);
    chk("lvd flag", 32'h0000_0010, rd);
    opt.lvd_en <= 1'b0;
    low_voltage_detector <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("lvd off", 0, core);
    low_voltage_detector <= 1'b0;
    repeat (2) @(posedge pclk);
    $display("test lvd done");
  endtask
  task automatic t_avd();
    opt.lvd_en <= 1'b1;
    apb(1, 12'h000, 32'h0000_0040);
    chk("enable high", 1, irq);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    auxiliary_supply_warning <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("warn irq", 1, irq);
    apb(0, 12'h000, 0);
    chk("warn flag", 32'h0000_0060, rd);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    @(posedge pclk);
    chk("ack", 0, irq);
    apb(1, 12'h000, 0);
    apb(1, 12'h000, 32'h0000_0040);
    repeat (2) @(posedge pclk);
    chk("enable low", 1, irq);
    opt.lvd_en <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(0, 12'h000, 0);
    chk("warn off", 0, {rd[5], irq});
    $display("test avd done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, wdg, ack, ext, low_voltage_detector, auxiliary_supply_warning} = '0;
    {errors, checks_done} = '0;
    paddr = '0;
    pwdata = '0;
    opt = 6'h0D;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    run_out();
    chk("clock path", 6'h17, clk_ctl);
    t_wdg();
    t_ext(1'b0);
    t_ext(1'b1);
    t_lvd();
    t_avd();
    test_done();
  end
  initial begin
    #400000;
    errors++;
    test_done();
  end
endmodule
bind rcs_sequencer rcs_sequencer_monitor mon (.pclk, .presetn, .psel,
  .penable, .pready, .opt, .lvd_below_i, .wdg_underflow_i, .rst_pin_i,
  .rst_pin_o, .rst_pin_oe_n, .core_reset_o, .vec_fetch_o, .vec_addr_o);
